// ==== design/tmw_pkg.sv ====
// Package for the 8-bit waveform timer: register map, field positions, modes.
// Assumes a single system clock; all users reference names as tmw_pkg::name.
package tmw_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_COUNT   = 2'h1;
    localparam logic [1:0] ADDR_COMPARE = 2'h2;
    localparam logic [1:0] ADDR_ASYNC   = 2'h3;

    // ==========================================================
    // Field positions
    localparam int BIT_FORCE     = 7;
    localparam int BIT_WGM_HI    = 6;
    localparam int BIT_COM_HI    = 5;
    localparam int BIT_COM_LO    = 4;
    localparam int BIT_WGM_LO    = 3;
    localparam int BIT_CS_HI     = 2;
    localparam int BIT_ASYNC_SEL = 3;

    // ==========================================================
    // Reset values and limits
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX     = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM  = 8'h00;

    // ==========================================================
    // Prescaler taps
    localparam int PRESCALE_W = 10;
    localparam logic [9:0] DIV8_MASK    = 10'h007;
    localparam logic [9:0] DIV32_MASK   = 10'h01F;
    localparam logic [9:0] DIV64_MASK   = 10'h03F;
    localparam logic [9:0] DIV128_MASK  = 10'h07F;
    localparam logic [9:0] DIV256_MASK  = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;

    // ==========================================================
    // Waveform modes
    typedef enum logic [1:0] {
        TMW_NORMAL    = 2'h0,
        TMW_PHASE_PWM = 2'h1,
        TMW_CLEAR_CMP = 2'h2,
        TMW_FAST_PWM  = 2'h3
    } tmw_mode_t;

    // Compare output mode codes.
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

endpackage : tmw_pkg

// ==== design/tmw_prescaler.sv ====
// Prescaler producing the single-cycle timer tick enable.
// Assumes source_tick is a one-cycle enable on clk_sys.
module tmw_prescaler (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       source_tick,
    input  wire logic [2:0] clock_select_field,
    output logic            timer_tick_enable
);

    logic [9:0] prescale_r;
    logic [9:0] mask;

    // ==========================================================
    // Free-running divider on the source clock.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prescale_r <= 10'h000;
        end else if (source_tick) begin
            prescale_r <= prescale_r + 10'h001;
        end
    end

    // ==========================================================
    // Tap selection.
    always_comb begin
        case (clock_select_field)
            3'h2:    mask = tmw_pkg::DIV8_MASK;
            3'h3:    mask = tmw_pkg::DIV32_MASK;
            3'h4:    mask = tmw_pkg::DIV64_MASK;
            3'h5:    mask = tmw_pkg::DIV128_MASK;
            3'h6:    mask = tmw_pkg::DIV256_MASK;
            3'h7:    mask = tmw_pkg::DIV1024_MASK;
            default: mask = 10'h000;
        endcase
    end

    // Code zero stops the counter; code one passes the source tick.
    assign timer_tick_enable = source_tick && (clock_select_field != 3'h0)
                               && ((prescale_r & mask) == mask);

endmodule : tmw_prescaler

// ==== design/tmw_timer.sv ====
// Top of the 8-bit waveform timer with register port and compare output.
// Assumes synchronous inputs on clk_sys; timer_osc_input is a one-cycle
// enable already synchronised to clk_sys.
//
// Summary of operation
// - Force strobe acts only in non-PWM modes.
// - Force applies compare action immediately.
// - Force sets no flag, clears no counter.
// - Force bit always reads zero.
// - Mode field bits 6,3 select top.
// - Compare buffer update and overflow timing.
// - Nonzero output mode overrides port pin.
// - Non-PWM codes: off, toggle, clear, set.
// - Fast PWM: clear/set on match, opposite bottom.
// - Fast PWM ignores match at top.
// - Phase PWM: up/down match actions.
// - Phase PWM top match acts at top.
// - Clock select picks prescaler tap.
// - Counter register fully readable and writable.
// - Counter write blocks next tick match.
// - Compare register compared continuously.
// - Async select chooses oscillator source.
// - Timer tick is clock enable only.
// - Async mode times from oscillator.
// - Fast PWM counts single slope.
// - Phase PWM dual slope, max once.
module tmw_timer (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       timer_osc_input,
    input  wire logic       flag_clear_overflow,
    input  wire logic       flag_clear_compare,
    output logic            overflow_flag,
    output logic            compare_flag,
    output logic            compare_output_pin,
    output logic            compare_output_enable
);

    logic [7:0]        count_r;
    logic [7:0]        compare_r;
    logic [7:0]        compare_buf_r;
    logic [1:0]        com_r;
    logic [2:0]        cs_r;
    logic              async_sel_r;
    logic              count_down_r;
    logic              block_match_r;
    logic              ocr_pin_r;
    logic              ovf_r;
    logic              cmpf_r;
    logic [7:0]        rdata_r;
    tmw_pkg::tmw_mode_t mode_r;

    logic              tick;
    logic              source_tick;
    logic              pwm_mode;
    logic [7:0]        top;
    logic              match;
    logic              at_top;
    logic              at_bottom;
    logic              ctrl_wr;
    logic              cnt_wr;
    logic              cmp_wr;
    logic              force_cmp;
    logic              ovf_event;
    logic              cmp_event;
    logic [7:0]        count_nxt;
    logic              down_nxt;

    // ==========================================================
    // Decode.
    assign ctrl_wr   = reg_write && (reg_addr == tmw_pkg::ADDR_CONTROL);
    assign cnt_wr    = reg_write && (reg_addr == tmw_pkg::ADDR_COUNT);
    assign cmp_wr    = reg_write && (reg_addr == tmw_pkg::ADDR_COMPARE);
    assign pwm_mode  = (mode_r == tmw_pkg::TMW_PHASE_PWM) || (mode_r == tmw_pkg::TMW_FAST_PWM);
    assign force_cmp = ctrl_wr && reg_wdata[tmw_pkg::BIT_FORCE]
                       && !reg_wdata[tmw_pkg::BIT_WGM_LO];

    // ==========================================================
    // Clock source and prescaler.
    assign source_tick = async_sel_r ? timer_osc_input : 1'b1;

    tmw_prescaler u_prescaler (
        .clk_sys            (clk_sys),
        .resetn             (resetn),
        .source_tick        (source_tick),
        .clock_select_field (cs_r),
        .timer_tick_enable  (tick)
    );

    // ==========================================================
    // Compare and top.
    assign top       = (mode_r == tmw_pkg::TMW_CLEAR_CMP) ? compare_r : tmw_pkg::COUNT_MAX;
    assign match     = (count_r == compare_r) && !block_match_r;
    assign at_top    = (count_r == tmw_pkg::COUNT_MAX);
    assign at_bottom = (count_r == tmw_pkg::COUNT_BOTTOM);

    // ==========================================================
    // Counter sequencing.
    always_comb begin
        count_nxt = count_r;
        down_nxt  = count_down_r;
        case (mode_r)
            tmw_pkg::TMW_CLEAR_CMP: begin
                count_nxt = match ? tmw_pkg::COUNT_BOTTOM : count_r + 8'h01;
                down_nxt  = 1'b0;
            end
            tmw_pkg::TMW_PHASE_PWM: begin
                if (count_down_r) begin
                    count_nxt = count_r - 8'h01;
                    down_nxt  = (count_r != 8'h01);
                end else if (at_top) begin
                    count_nxt = count_r - 8'h01;
                    down_nxt  = 1'b1;
                end else begin
                    count_nxt = count_r + 8'h01;
                end
            end
            default: begin
                count_nxt = count_r + 8'h01;
                down_nxt  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_r      <= tmw_pkg::COUNT_RESET;
            count_down_r <= 1'b0;
        end else if (cnt_wr) begin
            count_r      <= reg_wdata;
        end else if (tick) begin
            count_r      <= count_nxt;
            count_down_r <= down_nxt;
        end
    end

    // Match blocking after a counter write lasts until the next tick.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            block_match_r <= 1'b0;
        end else if (cnt_wr) begin
            block_match_r <= 1'b1;
        end else if (tick) begin
            block_match_r <= 1'b0;
        end
    end

    // ==========================================================
    // Control and compare registers.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_r <= tmw_pkg::TMW_NORMAL;
            com_r  <= tmw_pkg::COM_OFF;
            cs_r   <= 3'h0;
        end else if (ctrl_wr) begin
            mode_r <= tmw_pkg::tmw_mode_t'({reg_wdata[tmw_pkg::BIT_WGM_HI],
                                            reg_wdata[tmw_pkg::BIT_WGM_LO]});
            com_r  <= reg_wdata[tmw_pkg::BIT_COM_HI:tmw_pkg::BIT_COM_LO];
            cs_r   <= reg_wdata[tmw_pkg::BIT_CS_HI:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            async_sel_r <= 1'b0;
        end else if (reg_write && (reg_addr == tmw_pkg::ADDR_ASYNC)) begin
            async_sel_r <= reg_wdata[tmw_pkg::BIT_ASYNC_SEL];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            compare_buf_r <= tmw_pkg::COMPARE_RESET;
        end else if (cmp_wr) begin
            compare_buf_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            compare_r <= tmw_pkg::COMPARE_RESET;
        end else if (!pwm_mode) begin
            compare_r <= cmp_wr ? reg_wdata : compare_buf_r;
        end else if (tick && (((mode_r == tmw_pkg::TMW_PHASE_PWM) && at_top && !count_down_r)
                      || ((mode_r == tmw_pkg::TMW_FAST_PWM) && at_top))) begin
            compare_r <= compare_buf_r;
        end
    end

    // ==========================================================
    // Flags: hardware set wins over a clear in the same cycle.
    assign ovf_event = tick && ((mode_r == tmw_pkg::TMW_PHASE_PWM)
                       ? (count_down_r && (count_r == 8'h01)) : at_top);
    assign cmp_event = tick && match;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ovf_r <= 1'b0;
        end else if (ovf_event) begin
            ovf_r <= 1'b1;
        end else if (flag_clear_overflow) begin
            ovf_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmpf_r <= 1'b0;
        end else if (cmp_event) begin
            cmpf_r <= 1'b1;
        end else if (flag_clear_compare) begin
            cmpf_r <= 1'b0;
        end
    end

    // ==========================================================
    // Waveform generator.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ocr_pin_r <= 1'b0;
        end else if (force_cmp) begin
            case (reg_wdata[tmw_pkg::BIT_COM_HI:tmw_pkg::BIT_COM_LO])
                tmw_pkg::COM_TOGGLE: ocr_pin_r <= !ocr_pin_r;
                tmw_pkg::COM_CLEAR:  ocr_pin_r <= 1'b0;
                tmw_pkg::COM_SET:    ocr_pin_r <= 1'b1;
                default:             ocr_pin_r <= ocr_pin_r;
            endcase
        end else if (tick) begin
            case (mode_r)
                tmw_pkg::TMW_FAST_PWM: begin
                    if (com_r[1] && at_top) begin
                        ocr_pin_r <= !com_r[0];
                    end else if (com_r[1] && match && (compare_r != top)) begin
                        ocr_pin_r <= com_r[0];
                    end
                end
                tmw_pkg::TMW_PHASE_PWM: begin
                    if (com_r[1] && (compare_r == top) && at_top && !count_down_r) begin
                        ocr_pin_r <= !com_r[0];
                    end else if (com_r[1] && match && (compare_r != top)) begin
                        ocr_pin_r <= count_down_r ? !com_r[0] : com_r[0];
                    end
                end
                default: begin
                    if (match) begin
                        case (com_r)
                            tmw_pkg::COM_TOGGLE: ocr_pin_r <= !ocr_pin_r;
                            tmw_pkg::COM_CLEAR:  ocr_pin_r <= 1'b0;
                            tmw_pkg::COM_SET:    ocr_pin_r <= 1'b1;
                            default:             ocr_pin_r <= ocr_pin_r;
                        endcase
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Read port.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                tmw_pkg::ADDR_CONTROL: rdata_r <= {1'b0, mode_r[1], com_r, mode_r[0], cs_r};
                tmw_pkg::ADDR_COUNT:   rdata_r <= count_r;
                tmw_pkg::ADDR_COMPARE: rdata_r <= compare_buf_r;
                tmw_pkg::ADDR_ASYNC:   rdata_r <= {4'h0, async_sel_r, 3'h0};
                default:               rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata             = rdata_r;
    assign overflow_flag         = ovf_r;
    assign compare_flag          = cmpf_r;
    assign compare_output_pin    = ocr_pin_r;
    assign compare_output_enable = (com_r != tmw_pkg::COM_OFF);

endmodule : tmw_timer

// ==== verif/tmw_timer_chk.sv ====
// Assertion checker for tmw_timer, bound to every instance of it.
// Assumes one clock and register strobes held low while resetn is low.
module tmw_timer_chk (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       timer_osc_input,
    input wire logic       flag_clear_overflow,
    input wire logic       flag_clear_compare,
    input wire logic       overflow_flag,
    input wire logic       compare_flag,
    input wire logic       compare_output_pin,
    input wire logic       compare_output_enable
);
    // ==========================================================
    // Helper state
    logic [7:0] ctl_r;
    logic [3:0] stop_r;
    logic       ctl_wr;
    assign ctl_wr = reg_write && reg_addr == tmw_pkg::ADDR_CONTROL;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) ctl_r <= 8'h00;
        else if (ctl_wr) ctl_r <= reg_wdata;
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) stop_r <= 4'h0;
        else if (ctl_r[2:0] != 3'h0 || (ctl_wr && reg_wdata[2:0] != 3'h0)) stop_r <= 4'h0;
        else if (stop_r != 4'hF) stop_r <= stop_r + 4'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Properties
    sequence s_force;
        ctl_wr && reg_wdata[7] && reg_wdata[2:0] == 3'h0 && stop_r > 4'h3;
    endsequence
    property p_oe;
        compare_output_enable == (ctl_r[5:4] != 2'h0);
    endproperty
    property p_rd_idle;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    property p_rd_force;
        $past(reg_read && reg_addr == tmw_pkg::ADDR_CONTROL) |-> !reg_rdata[7];
    endproperty
    property p_rd_async;
        $past(reg_read && reg_addr == tmw_pkg::ADDR_ASYNC) |-> (reg_rdata & 8'hF7) == 8'h00;
    endproperty
    property p_force_set;
        s_force ##0 (!reg_wdata[3] && reg_wdata[5:4] == tmw_pkg::COM_SET) |=> compare_output_pin;
    endproperty
    property p_force_clr;
        s_force ##0 (!reg_wdata[3] && reg_wdata[5:4] == tmw_pkg::COM_CLEAR) |=> !compare_output_pin;
    endproperty
    property p_force_tog;
        s_force ##0 (!reg_wdata[3] && reg_wdata[5:4] == tmw_pkg::COM_TOGGLE)
            |=> compare_output_pin != $past(compare_output_pin);
    endproperty
    property p_force_pwm;
        s_force ##0 reg_wdata[3] |=> $stable(compare_output_pin);
    endproperty
    property p_force_flag;
        s_force |=> !$rose(compare_flag) ##1 !$rose(compare_flag);
    endproperty
    property p_stop_hold;
        stop_r > 4'h3 |-> !$rose(overflow_flag);
    endproperty
    a_oe: assert property (p_oe) else $error("enable differs from mode field");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_rd_force: assert property (p_rd_force) else $error("strobe bit read as one");
    a_rd_async: assert property (p_rd_async) else $error("status spare bits set");
    a_force_set: assert property (p_force_set) else $error("forced set missing");
    a_force_clr: assert property (p_force_clr) else $error("forced clear missing");
    a_force_tog: assert property (p_force_tog) else $error("forced toggle missing");
    a_force_pwm: assert property (p_force_pwm) else $error("strobe acted in pwm");
    a_force_flag: assert property (p_force_flag) else $error("strobe set a flag");
    a_stop_hold: assert property (p_stop_hold) else $error("overflow while stopped");
endmodule : tmw_timer_chk

bind tmw_timer tmw_timer_chk u_chk (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_osc_input(timer_osc_input),
    .flag_clear_overflow(flag_clear_overflow), .flag_clear_compare(flag_clear_compare),
    .overflow_flag(overflow_flag), .compare_flag(compare_flag),
    .compare_output_pin(compare_output_pin), .compare_output_enable(compare_output_enable));

// ==== verif/tb.sv ====
// Self-checking bench for tmw_timer through its register port.
// Assumes the checker binds itself; one 125 MHz clock.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys, resetn, reg_write, reg_read, timer_osc_input;
    logic       flag_clear_overflow, flag_clear_compare;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       overflow_flag, compare_flag, compare_output_pin, compare_output_enable;
    int         num_errors;
    int         comparisons;
    tmw_timer u_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .timer_osc_input(timer_osc_input),
        .flag_clear_overflow(flag_clear_overflow), .flag_clear_compare(flag_clear_compare),
        .overflow_flag(overflow_flag), .compare_flag(compare_flag),
        .compare_output_pin(compare_output_pin),
        .compare_output_enable(compare_output_enable));
    // ==========================================================
    // Bus tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic stop(input logic [7:0] c);
        wr(2'h0, c);
        cyc(4);
    endtask : stop
    task automatic clr;
        @(posedge clk_sys);
        flag_clear_overflow <= 1'b1;
        flag_clear_compare <= 1'b1;
        @(posedge clk_sys);
        flag_clear_overflow <= 1'b0;
        flag_clear_compare <= 1'b0;
        #1;
    endtask : clr
    task automatic wait_flag(input bit sel);
        int n;
        n = 0;
        while ((sel ? compare_flag : overflow_flag) !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        if ((sel ? compare_flag : overflow_flag) !== 1'b1) begin
            num_errors++;
            summarize();
        end
    endtask : wait_flag
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    // ==========================================================
    // Stimulus
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        logic [7:0]  d, v;
        logic [15:0] hi;
        int          p;
        {resetn, reg_write, reg_read, timer_osc_input} = 4'h0;
        {flag_clear_overflow, flag_clear_compare, reg_addr, reg_wdata} = 12'h000;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            rd(2'(a), d);
            `CHK(d, 8'h00)
        end
        wr(2'h1, 8'hA5);
        rd(2'h1, d);
        `CHK(d, 8'hA5)
        wr(2'h2, 8'h5A);
        rd(2'h2, d);
        `CHK(d, 8'h5A)
        wr(2'h3, 8'hFF);
        rd(2'h3, d);
        `CHK(d, 8'h08)
        wr(2'h3, 8'h00);
        $display("registers done");
        stop(8'h00);
        wr(2'h0, 8'hB0);
        `CHK(compare_output_pin, 1'b1)
        `CHK(compare_output_enable, 1'b1)
        rd(2'h0, d);
        `CHK(d, 8'h30)
        wr(2'h0, 8'hA0);
        `CHK(compare_output_pin, 1'b0)
        for (int t = 0; t < 2; t++) begin
            wr(2'h0, 8'h90);
            `CHK(compare_output_pin, 1'(t == 0))
        end
        wr(2'h0, 8'h00);
        `CHK(compare_output_enable, 1'b0)
        wr(2'h0, 8'hB8);
        `CHK(compare_output_pin, 1'b0)
        stop(8'h40);
        wr(2'h1, 8'h02);
        wr(2'h0, 8'hD0);
        rd(2'h1, d);
        `CHK(d, 8'h02)
        `CHK(compare_flag, 1'b0)
        $display("force done");
        stop(8'h00);
        wr(2'h2, 8'hFE);
        wr(2'h1, 8'hFC);
        wr(2'h0, 8'h01);
        wait_flag(1'b1);
        wait_flag(1'b0);
        stop(8'h00);
        clr();
        `CHK({overflow_flag, compare_flag}, 2'h0)
        wr(2'h2, 8'h05);
        wr(2'h1, 8'h05);
        wr(2'h0, 8'h01);
        cyc(3);
        `CHK(compare_flag, 1'b0)
        stop(8'h00);
        wr(2'h1, 8'h00);
        wr(2'h2, 8'h03);
        wr(2'h0, 8'h51);
        cyc(40);
        stop(8'h40);
        rd(2'h1, d);
        `CHK(d <= 8'h03 && compare_flag, 1'b1)
        $display("flags done");
        for (int k = 1; k < 8; k++) begin
            p = (k == 1) ? 1 : (k == 2) ? 8 : (k == 7) ? 1024 : (1 << (k + 2));
            stop(8'h00);
            wr(2'h1, 8'h00);
            wr(2'h0, 8'(k));
            cyc(4 * p - 2);
            stop(8'h00);
            rd(2'h1, d);
            `CHK(d >= 8'h03 && d <= 8'h05, 1'b1)
        end
        wr(2'h3, 8'h08);
        wr(2'h1, 8'h00);
        wr(2'h0, 8'h01);
        repeat (10) begin
            @(posedge clk_sys);
            timer_osc_input <= 1'b1;
            @(posedge clk_sys);
            timer_osc_input <= 1'b0;
            cyc(2);
        end
        stop(8'h00);
        rd(2'h1, d);
        `CHK(d >= 8'h08 && d <= 8'h0B, 1'b1)
        wr(2'h3, 8'h00);
        wr(2'h1, 8'h00);
        $display("clocking done");
        for (int m = 0; m < 2; m++)
            for (int c = 2; c < 4; c++)
                for (int k = 0; k < 2; k++) begin
                    p = m ? 510 : 256;
                    v = k ? 8'hFF : 8'h80;
                    stop(8'h00);
                    wr(2'h1, 8'h00);
                    wr(2'h2, v);
                    wr(2'h0, (m ? 8'h08 : 8'h48) | 8'(c << 4) | 8'h01);
                    cyc(2 * p);
                    hi = 16'h0000;
                    repeat (2 * p) begin
                        cyc(1);
                        hi += 16'(compare_output_pin);
                    end
                    if (k == 1)
                        `CHK(hi, 16'((c == 2) ? 2 * p : 0))
                    else
                        `CHK(hi >= 16'(p - 8) && hi <= 16'(p + 8), 1'b1)
                end
        $display("waveforms done");
        summarize();
    end
endmodule : tb
